/* File: clsio_pkg.sv */
// constants for the clocked serial mode block
package clsio_pkg;
  // register byte offsets
  localparam logic [3:0] CLSIO_CTRL_A_OFS = 4'h0;
  localparam logic [3:0] CLSIO_DATA_OFS = 4'h4;
  localparam logic [3:0] CLSIO_STATUS_B_OFS = 4'h8;
  localparam logic [3:0] CLSIO_MODE_OFS = 4'hC;
  // serial_control_a fields
  localparam int CLSIO_START_BIT = 7;
  localparam int CLSIO_ABORT_BIT = 6;
  localparam int CLSIO_DIR_LSB = 4;
  localparam int CLSIO_CKS_LSB = 0;
  // serial_status_b fields
  localparam int CLSIO_ACTIVE_BIT = 3;
  localparam int CLSIO_SHIFT_BIT = 2;
  localparam logic [7:0] CLSIO_STATUS_ONES = 8'hF3;
  // transfer_direction_field codes
  localparam logic [1:0] CLSIO_DIR_TX = 2'h0;
  localparam logic [1:0] CLSIO_DIR_RSVD = 2'h1;
  localparam logic [1:0] CLSIO_DIR_RX = 2'h2;
  localparam logic [1:0] CLSIO_DIR_TRX = 2'h3;
  // clock select and interface mode
  localparam logic [2:0] CLSIO_CKS_EXT = 3'h7;
  localparam logic [1:0] CLSIO_IFMODE_SIO = 2'h1;
  // reset values
  localparam logic [1:0] CLSIO_DIR_RST = 2'h0;
  localparam logic [2:0] CLSIO_CKS_RST = 3'h0;
  localparam logic [1:0] CLSIO_IFMODE_RST = 2'h0;
  // internal shift clock half period base, in clocks, doubled per select step
  localparam int CLSIO_HALF_BASE = 8;
  localparam int CLSIO_BITS = 8;
  // external clock phases, four machine cycles of 250 ns each
  localparam int CLSIO_CLK_NS = 4;
  localparam int CLSIO_EXT_MIN_PULSE_NS = 1000;
  localparam int CLSIO_EXT_MIN_PULSE_CYC = (CLSIO_EXT_MIN_PULSE_NS + CLSIO_CLK_NS - 1) / CLSIO_CLK_NS;
  localparam logic [1:0] CLSIO_RESP_OKAY = 2'h0;
  localparam logic [1:0] CLSIO_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CLSIO_ST_IDLE,
    CLSIO_ST_WAIT,
    CLSIO_ST_SHIFT
  } clsio_state_t;
endpackage

/* File: clsio_top.sv */
// clocked serial 8-bit transfer mode with an AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// R1: seven internal shift clock rates, driven out
// R2: shift clock idles high at transfer start
// R3: internal clock halts until buffer serviced
// R4: select 111 uses external clock, wide phases
// R5: external clock at most 500 kHz
// R6: send on falling, sample on rising edge
// R7: direction field picks transmit, receive, duplex
// R8: transmit loads buffer, shifts out LSB first
// R9: buffer to shifter empties buffer, interrupts in transmit-only
// R10: internal transmit waits for new data
// R11: transmit-only output high until first bit
// R12: start clear finishes, abort stops at once
// R13: transfer-active flag at status bit 3
// R14: external transmit needs data before next shift
// R15: receive LSB first, byte to buffer, interrupt
// R16: external receive drops data if unread
// R17: internal receive waits until buffer read
// R18: unread byte is overwritten by newer byte
// R19: start clear delivers whole bytes only
// R20: changing direction discards buffer contents
// R21: duplex waits for read and write
// R22: duplex output repeats previous last bit
// R23: interface mode 01 selects this mode
// R24: shift-active flag at status bit 2
// R25: reset leaves block idle, clock high
module clsio_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n,
  output logic so_o,
  output logic so_oe_n,
  input wire logic si_i,
  // buffer empty or full event
  output logic serial_port_irq
);
  import clsio_pkg::*;
  clsio_state_t st;
  logic aw_got, w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic transfer_start_bit;
  logic [1:0] transfer_direction_field;
  logic [2:0] clk_select;
  logic [1:0] bus_interface_mode_field;
  logic [7:0] serial_data_buffer;
  logic tx_valid, rx_full;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [15:0] divcnt;
  logic sck_int;
  logic dummy_end;
  logic transfer_active_flag;
  logic sck_s1, sck_s2, sck_s3;
  logic si_s1, si_s2;

  // bus decode
  logic wr_go, wr_ctrl, wr_dat, wr_mode, rd_go, rd_dat, abort_req, dir_change;
  assign wr_go = aw_got && w_got && !bvalid;
  assign wr_ctrl = wr_go && aw_addr == CLSIO_CTRL_A_OFS && w_strb[0];
  assign wr_dat = wr_go && aw_addr == CLSIO_DATA_OFS && w_strb[0];
  assign wr_mode = wr_go && aw_addr == CLSIO_MODE_OFS && w_strb[0];
  assign rd_go = arvalid && arready;
  assign rd_dat = rd_go && {araddr[3:2], 2'h0} == CLSIO_DATA_OFS;
  assign abort_req = wr_ctrl && w_data[CLSIO_ABORT_BIT];
  assign dir_change = wr_ctrl && w_data[CLSIO_DIR_LSB +: 2] != transfer_direction_field;

  // mode decode
  logic sio_on, ext_clk, tx_path, rx_path, dir_ok, ready_next;
  assign sio_on = bus_interface_mode_field == CLSIO_IFMODE_SIO; // R23
  assign ext_clk = clk_select == CLSIO_CKS_EXT; // R4
  assign tx_path = transfer_direction_field != CLSIO_DIR_RX; // R7
  assign rx_path = transfer_direction_field != CLSIO_DIR_TX; // R7
  assign dir_ok = transfer_direction_field != CLSIO_DIR_RSVD;
  assign ready_next = (!tx_path || tx_valid) && (!rx_path || !rx_full); // R3 R21

  // shift edges
  logic [15:0] half_cnt;
  logic fall_ev, rise_ev, byte_done;
  logic [7:0] rx_byte;
  assign half_cnt = 16'(CLSIO_HALF_BASE) << clk_select; // R1
  assign fall_ev = st == CLSIO_ST_SHIFT &&
                   (ext_clk ? (sck_s3 && !sck_s2) : (divcnt == 16'h0 && sck_int)); // R6
  assign rise_ev = st == CLSIO_ST_SHIFT &&
                   (ext_clk ? (!sck_s3 && sck_s2) : (divcnt == 16'h0 && !sck_int)); // R6
  assign byte_done = rise_ev && bitcnt == 3'(CLSIO_BITS - 1);
  assign rx_byte = {rx_path ? si_s2 : 1'b0, shreg[7:1]};

  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_s1 <= 1'b1;
      sck_s2 <= 1'b1;
      sck_s3 <= 1'b1;
      si_s1 <= 1'b0;
      si_s2 <= 1'b0;
    end else begin
      sck_s1 <= sck_i;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      si_s1 <= si_i;
      si_s2 <= si_s1;
    end
  end

  // axi write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= CLSIO_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        awready <= 1'b0;
        aw_addr <= {awaddr[3:2], 2'h0};
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        wready <= 1'b0;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr == CLSIO_STATUS_B_OFS) ? CLSIO_RESP_SLVERR : CLSIO_RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= CLSIO_RESP_OKAY;
    end else begin
      if (rd_go) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= CLSIO_RESP_OKAY;
        unique case ({araddr[3:2], 2'h0})
          CLSIO_CTRL_A_OFS: begin
            rdata <= {24'h0, transfer_start_bit, 1'b0, transfer_direction_field, 1'b0, clk_select};
          end
          CLSIO_DATA_OFS: rdata <= {24'h0, serial_data_buffer};
          CLSIO_STATUS_B_OFS: begin
            rdata <= {24'h0, CLSIO_STATUS_ONES | ({7'h0, transfer_active_flag} << CLSIO_ACTIVE_BIT) |
                      ({7'h0, st == CLSIO_ST_SHIFT} << CLSIO_SHIFT_BIT)}; // R13 R24
          end
          CLSIO_MODE_OFS: rdata <= {30'h0, bus_interface_mode_field};
        endcase
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transfer_start_bit <= 1'b0; // R25
      transfer_direction_field <= CLSIO_DIR_RST;
      clk_select <= CLSIO_CKS_RST;
      bus_interface_mode_field <= CLSIO_IFMODE_RST;
    end else begin
      if (wr_ctrl) begin
        transfer_start_bit <= w_data[CLSIO_START_BIT] && !w_data[CLSIO_ABORT_BIT];
        transfer_direction_field <= w_data[CLSIO_DIR_LSB +: 2];
        clk_select <= w_data[CLSIO_CKS_LSB +: 3];
      end else if (dummy_end) begin
        transfer_start_bit <= 1'b0; // R14
      end
      if (wr_mode) begin
        bus_interface_mode_field <= w_data[1:0];
      end
    end
  end

  logic dummy_pending;
  assign dummy_end = byte_done && dummy_pending;

  // transfer sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= CLSIO_ST_IDLE;
      transfer_active_flag <= 1'b0; // R25
      shreg <= 8'h0;
      bitcnt <= 3'h0;
      divcnt <= 16'h0;
      sck_int <= 1'b1;
      so_o <= 1'b1;
      dummy_pending <= 1'b0;
    end else if (abort_req || !sio_on) begin
      st <= CLSIO_ST_IDLE; // R12 R19
      transfer_active_flag <= 1'b0;
      shreg <= 8'h0;
      bitcnt <= 3'h0;
      sck_int <= 1'b1;
      dummy_pending <= 1'b0;
    end else begin
      unique case (st)
        CLSIO_ST_IDLE: begin
          sck_int <= 1'b1; // R2
          if (transfer_start_bit && dir_ok) begin
            st <= CLSIO_ST_WAIT;
            transfer_active_flag <= 1'b1; // R13
            if (transfer_direction_field == CLSIO_DIR_TX) begin
              so_o <= 1'b1; // R11
            end
          end
        end
        CLSIO_ST_WAIT: begin
          sck_int <= 1'b1; // R3 R10 R17
          if (!transfer_start_bit) begin
            st <= CLSIO_ST_IDLE; // R12
            transfer_active_flag <= 1'b0;
            shreg <= 8'h0; // R11
          end else if (ready_next) begin
            st <= CLSIO_ST_SHIFT; // R21
            if (tx_path) begin
              shreg <= serial_data_buffer; // R8
            end
            bitcnt <= 3'h0;
            divcnt <= half_cnt - 16'h1;
          end
        end
        CLSIO_ST_SHIFT: begin
          if (!ext_clk) begin
            if (divcnt == 16'h0) begin
              sck_int <= !sck_int; // R1
              divcnt <= half_cnt - 16'h1;
            end else begin
              divcnt <= divcnt - 16'h1;
            end
          end
          if (fall_ev && tx_path) begin
            so_o <= shreg[0]; // R6 R8 R22
          end
          if (rise_ev) begin
            shreg <= rx_byte; // R15
            bitcnt <= bitcnt + 3'h1;
          end
          if (byte_done) begin
            bitcnt <= 3'h0;
            if (!transfer_start_bit || dummy_pending) begin
              st <= CLSIO_ST_IDLE; // R12 R19
              transfer_active_flag <= 1'b0;
              shreg <= 8'h0; // R11
              dummy_pending <= 1'b0;
            end else if (!ext_clk) begin
              st <= CLSIO_ST_WAIT; // R3 R10 R17 R21
            end else if (tx_path && !tx_valid) begin
              shreg <= 8'h0; // R14
              dummy_pending <= 1'b1;
            end else if (tx_path) begin
              shreg <= serial_data_buffer; // R8
            end
          end
        end
        default: begin
          st <= CLSIO_ST_IDLE;
        end
      endcase
    end
  end

  // shared data buffer and its flags
  logic load_tx;
  assign load_tx = tx_path && !abort_req && sio_on && transfer_start_bit &&
                   ((st == CLSIO_ST_WAIT && ready_next) ||
                    (byte_done && ext_clk && tx_valid && !dummy_pending));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_data_buffer <= 8'h0;
      tx_valid <= 1'b0;
      rx_full <= 1'b0;
      serial_port_irq <= 1'b0;
    end else begin
      serial_port_irq <= 1'b0;
      if (dir_change) begin
        serial_data_buffer <= 8'h0; // R20
        tx_valid <= 1'b0;
        rx_full <= 1'b0;
      end else begin
        if (rd_dat) begin
          rx_full <= 1'b0;
        end
        if (load_tx) begin
          tx_valid <= 1'b0; // R9
          serial_port_irq <= !rx_path; // R9
        end
        if (wr_dat) begin
          serial_data_buffer <= w_data[7:0];
          tx_valid <= 1'b1;
        end
        if (byte_done && rx_path && !abort_req && sio_on) begin
          serial_data_buffer <= rx_byte; // R15 R16 R18 R19
          rx_full <= 1'b1;
          serial_port_irq <= 1'b1; // R15
        end
      end
    end
  end

  // pin drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_o <= 1'b1; // R25
      sck_oe_n <= 1'b1;
      so_oe_n <= 1'b1;
    end else begin
      sck_o <= ext_clk ? 1'b1 : sck_int; // R1 R2
      sck_oe_n <= !(sio_on && !ext_clk); // R1 R4
      so_oe_n <= !sio_on; // R23
    end
  end
endmodule // clsio_top

`default_nettype wire

/* File: clsio_dummy_unused.sv */
// spare source unit that holds no logic
`default_nettype none
`default_nettype wire

/* File: clsio_props.sv */
// assertion checker for the clocked serial block
`timescale 1ns/10ps
`default_nettype none
module clsio_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // serial side
  input wire logic sck_o,
  input wire logic sck_oe_n,
  input wire logic serial_port_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [9:0] run;
  logic last;
  // cycles since the shift clock output last changed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= 10'h000;
      last <= 1'b1;
    end else begin
      last <= sck_o;
      run <= (sck_o != last) ? 10'h001 : ((run == 10'h3FF) ? run : run + 10'h001);
    end
  end
  property p_rst; $rose(aresetn) |-> sck_o && sck_oe_n && !serial_port_irq && !bvalid && !rvalid; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_rate; $rose(sck_o) && !sck_oe_n |-> run inside {10'h8, 10'h10, 10'h20, 10'h40, 10'h80, 10'h100, 10'h200}; endproperty
  a_rate: assert property (p_rate) else $error("shift clock low half wrong");
  property p_idle; $fell(sck_o) && !sck_oe_n |-> run >= 10'h008; endproperty
  a_idle: assert property (p_idle) else $error("shift clock not high before fall");
  property p_ext; sck_oe_n |-> sck_o; endproperty
  a_ext: assert property (p_ext) else $error("shift clock output not high when released");
  property p_irq; serial_port_irq |=> !serial_port_irq; endproperty
  a_irq: assert property (p_irq) else $error("irq longer than one cycle");
  property p_aw; awvalid && awready && wvalid && wready |=> !awready && !wready ##1 bvalid; endproperty
  a_aw: assert property (p_aw) else $error("write response late");
  property p_b; bvalid && bready |=> !bvalid && awready && wready; endproperty
  a_b: assert property (p_b) else $error("write channel not freed");
  property p_ar; arvalid && arready |=> rvalid && !arready; endproperty
  a_ar: assert property (p_ar) else $error("read data late");
  property p_r; rvalid && rready |=> !rvalid && arready; endproperty
  a_r: assert property (p_r) else $error("read channel not freed");
endmodule // clsio_props
bind clsio_top clsio_props u_props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .bready, .arvalid, .arready, .rvalid, .rready, .sck_o, .sck_oe_n, .serial_port_irq);
`default_nettype wire

/* File: clsio_peer.sv */
// far-side serial peripheral model
`timescale 1ns/10ps
`default_nettype none
module clsio_peer (
  // pins from the block
  input wire logic sck_o,
  input wire logic sck_oe_n,
  input wire logic so_o,
  // pins to the block
  output logic sck_i,
  output logic si_i,
  // bytes sent and seen
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  wire logic line;
  int n = 0;
  int nb = 0;
  assign line = sck_oe_n ? sck_i : sck_o;
  initial begin
    sck_i = 1'b1;
    si_i = 1'b0;
    rx_byte = 8'h00;
  end
  // external clock, 32 ns period, high outside frames
  task automatic burst(input int k);
    #1.3;
    repeat (k) begin
      sck_i = 1'b0;
      #16;
      sck_i = 1'b1;
      #16;
    end
  endtask
  always @(negedge line) si_i = tx_byte[n];
  always @(posedge line) begin
    rx_byte = {so_o, rx_byte[7:1]};
    n = (n + 1) % 8;
    if (n == 0) begin
      nb++;
      #20;
      si_i = ~si_i;
    end
  end
endmodule // clsio_peer
`default_nettype wire

/* File: clocked_serial_sio_mode_tb.sv */
// self-checking bench for the clocked serial block
`timescale 1ns/10ps
`default_nettype none
module clocked_serial_sio_mode_tb;
  import clsio_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sck_i, si_i;
  logic awready, wready, bvalid, arready, rvalid, sck_o, sck_oe_n, so_o, so_oe_n, serial_port_irq;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] tx_byte, rx_byte;
  int errors = 0;
  int checks = 0;
  int irqs = 0;
  int b, n0;
  clsio_top u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sck_i, .sck_o,
    .sck_oe_n, .so_o, .so_oe_n, .si_i, .serial_port_irq);
  clsio_peer u_peer (.sck_o, .sck_oe_n, .so_o, .sck_i, .si_i, .tx_byte, .rx_byte);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) if (serial_port_irq === 1'b1) irqs++;
  function automatic logic [7:0] cv(input logic s, input logic [1:0] d, input logic [2:0] c);
    return {s, 1'b0, d, 1'b0, c};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        rsp = bresp;
        return;
      end
    end
    chk("bvalid", 1, 0);
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        return;
      end
    end
    chk("rvalid", 1, 0);
  endtask
  task automatic wait_irq(input int k);
    for (int i = 0; i < 20000 && irqs < k; i++) @(posedge aclk);
    chk("irqs", k, irqs);
  endtask
  task automatic wait_byte(input int k);
    for (int i = 0; i < 20000 && u_peer.nb < k; i++) @(posedge aclk);
    chk("bytes", k, u_peer.nb);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      rdr(CLSIO_STATUS_B_OFS);
      if (rd[CLSIO_ACTIVE_BIT] === 1'b0) break;
    end
    chk("status", {24'h0, CLSIO_STATUS_ONES}, rd);
  endtask
  task automatic t_reset();
    chk("sck", 1, sck_o);
    rdr(CLSIO_STATUS_B_OFS);
    chk("status", {24'h0, CLSIO_STATUS_ONES}, rd);
    rdr(CLSIO_CTRL_A_OFS);
    chk("ctrl", 0, rd);
    wr(CLSIO_STATUS_B_OFS, 8'hFF);
    chk("bresp", CLSIO_RESP_SLVERR, rsp);
    chk("sck_oe_n", 1, sck_oe_n);
    wr(CLSIO_MODE_OFS, {6'h00, CLSIO_IFMODE_SIO});
    @(posedge aclk);
    chk("so_oe_n", 0, so_oe_n);
    wr(CLSIO_DATA_OFS, 8'h77);
    wr(CLSIO_CTRL_A_OFS, cv(0, CLSIO_DIR_RX, 3'h0));
    rdr(CLSIO_DATA_OFS);
    chk("buffer", 0, rd);
    $display("reset test done");
  endtask
  task automatic t_tx();
    wr(CLSIO_CTRL_A_OFS, cv(0, CLSIO_DIR_TX, 3'h0));
    wr(CLSIO_DATA_OFS, 8'h5A);
    b = irqs;
    n0 = u_peer.nb;
    wr(CLSIO_CTRL_A_OFS, cv(1, CLSIO_DIR_TX, 3'h0));
    chk("so", 1, so_o);
    wait_irq(b + 1);
    rdr(CLSIO_STATUS_B_OFS);
    chk("active", 1, rd[CLSIO_ACTIVE_BIT]);
    wait_byte(n0 + 1);
    chk("tx byte", 8'h5A, rx_byte);
    repeat (100) @(posedge aclk);
    chk("sck", 1, sck_o);
    chk("bytes", n0 + 1, u_peer.nb);
    wr(CLSIO_DATA_OFS, 8'h3C);
    wr(CLSIO_CTRL_A_OFS, cv(0, CLSIO_DIR_TX, 3'h0));
    wait_byte(n0 + 2);
    chk("tx byte", 8'h3C, rx_byte);
    wait_idle();
    $display("transmit test done");
  endtask
  task automatic t_rx();
    wr(CLSIO_CTRL_A_OFS, cv(0, CLSIO_DIR_RX, 3'h1));
    tx_byte <= 8'hC3;
    b = irqs;
    n0 = u_peer.nb;
    wr(CLSIO_CTRL_A_OFS, cv(1, CLSIO_DIR_RX, 3'h1));
    wait_irq(b + 1);
    tx_byte <= 8'h96;
    repeat (200) @(posedge aclk);
    chk("sck", 1, sck_o);
    chk("bytes", n0 + 1, u_peer.nb);
    rdr(CLSIO_DATA_OFS);
    chk("rx byte", 8'hC3, rd);
    wr(CLSIO_CTRL_A_OFS, cv(0, CLSIO_DIR_RX, 3'h1));
    wait_irq(b + 2);
    rdr(CLSIO_DATA_OFS);
    chk("rx byte", 8'h96, rd);
    wait_idle();
    $display("receive test done");
  endtask
  task automatic t_dup();
    wr(CLSIO_CTRL_A_OFS, cv(0, CLSIO_DIR_TRX, 3'h0));
    wr(CLSIO_DATA_OFS, 8'h81);
    tx_byte <= 8'h42;
    b = irqs;
    n0 = u_peer.nb;
    wr(CLSIO_CTRL_A_OFS, cv(1, CLSIO_DIR_TRX, 3'h0));
    chk("so", 0, so_o);
    wait_irq(b + 1);
    wait_byte(n0 + 1);
    chk("tx byte", 8'h81, rx_byte);
    rdr(CLSIO_DATA_OFS);
    chk("rx byte", 8'h42, rd);
    repeat (50) @(posedge aclk);
    chk("bytes", n0 + 1, u_peer.nb);
    wr(CLSIO_DATA_OFS, 8'h18);
    wr(CLSIO_CTRL_A_OFS, cv(0, CLSIO_DIR_TRX, 3'h0));
    wait_byte(n0 + 2);
    chk("tx byte", 8'h18, rx_byte);
    wait_idle();
    $display("duplex test done");
  endtask
  task automatic t_ext();
    wr(CLSIO_CTRL_A_OFS, cv(0, CLSIO_DIR_TX, CLSIO_CKS_EXT));
    wr(CLSIO_DATA_OFS, 8'hA5);
    wr(CLSIO_CTRL_A_OFS, cv(1, CLSIO_DIR_TX, CLSIO_CKS_EXT));
    wr(CLSIO_DATA_OFS, 8'h5C);
    u_peer.burst(8);
    chk("tx byte", 8'hA5, rx_byte);
    wr(CLSIO_CTRL_A_OFS, cv(0, CLSIO_DIR_TX, CLSIO_CKS_EXT));
    u_peer.burst(8);
    chk("tx byte", 8'h5C, rx_byte);
    wait_idle();
    wr(CLSIO_CTRL_A_OFS, cv(0, CLSIO_DIR_RX, CLSIO_CKS_EXT));
    chk("sck_oe_n", 1, sck_oe_n);
    tx_byte <= 8'h69;
    b = irqs;
    wr(CLSIO_CTRL_A_OFS, cv(1, CLSIO_DIR_RX, CLSIO_CKS_EXT));
    u_peer.burst(8);
    wait_irq(b + 1);
    tx_byte <= 8'h12;
    repeat (10) @(posedge aclk);
    u_peer.burst(8);
    wait_irq(b + 2);
    rdr(CLSIO_DATA_OFS);
    chk("rx byte", 8'h12, rd);
    u_peer.burst(3);
    wr(CLSIO_CTRL_A_OFS, 8'h40 | cv(0, CLSIO_DIR_RX, CLSIO_CKS_EXT));
    rdr(CLSIO_STATUS_B_OFS);
    chk("status", {24'h0, CLSIO_STATUS_ONES}, rd);
    rdr(CLSIO_CTRL_A_OFS);
    chk("ctrl", {24'h0, cv(0, CLSIO_DIR_RX, CLSIO_CKS_EXT)}, rd);
    $display("external clock test done");
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {aresetn, awvalid, wvalid, arvalid} = 4'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wstrb, wdata, tx_byte} = {8'h00, 4'hF, 32'h0, 8'h00};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    u_peer.n = 0;
    u_peer.nb = 0;
    t_reset();
    t_tx();
    t_rx();
    t_dup();
    t_ext();
    wrap_up();
  end
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
endmodule // clocked_serial_sio_mode_tb
`default_nettype wire
